// ==== ref_clock_pkg.sv ====
`default_nettype none

package ref_clock_pkg;

	// ==========================================================================
	// Register bus
	// ==========================================================================
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;

	localparam logic [3:0] REG_MODE      = 4'h0;
	localparam logic [3:0] REG_HOLDOFF   = 4'h1;
	localparam logic [3:0] REG_CFG       = 4'h2;
	localparam logic [3:0] REG_PRIO      = 4'h3;
	localparam logic [3:0] REG_STATUS    = 4'h4;
	localparam logic [3:0] REG_LATCH_CLR = 4'h5;

	// ==========================================================================
	// Field positions
	// ==========================================================================
	localparam int MODE_SEL_LSB  = 0;
	localparam int MAN_SEL_LSB   = 2;
	localparam int REVERTIVE_SWITCH_ENABLE_BIT      = 4;
	localparam int PRESC_BIT     = 5;
	localparam int MASK_BIT      = 6;
	localparam int CFG_DIV_LSB   = 0;
	localparam int CFG_REVAL_LSB = 2;
	localparam int CFG_PD_LSB    = 4;

	// ==========================================================================
	// Reset values
	// ==========================================================================
	localparam logic [7:0] MODE_RST    = 8'h00;
	localparam logic [7:0] HOLDOFF_RST = 8'h80;
	localparam logic [7:0] CFG_RST     = 8'h0A;
	localparam logic [7:0] PRIO_RST    = 8'h1B;

	// ==========================================================================
	// Modes and counts
	// ==========================================================================
	localparam logic [1:0] MODE_MANUAL     = 2'h0;
	localparam logic [1:0] MODE_AUTO       = 2'h1;
	localparam logic [1:0] MODE_SHORT_HOLD = 2'h2;
	localparam logic [1:0] MODE_AUTO_HOLD  = 2'h3;

	localparam int REVAL_W = 9;
	localparam logic [8:0] REVAL_X1_0 = 9'h002;
	localparam logic [8:0] REVAL_X1_1 = 9'h010;
	localparam logic [8:0] REVAL_X1_2 = 9'h020;
	localparam logic [8:0] REVAL_X1_3 = 9'h040;
	localparam logic [8:0] REVAL_X4_0 = 9'h008;
	localparam logic [8:0] REVAL_X4_1 = 9'h040;
	localparam logic [8:0] REVAL_X4_2 = 9'h080;
	localparam logic [8:0] REVAL_X4_3 = 9'h100;

	localparam int VCXO_CNT_W = 17;
	localparam logic [16:0] TICK_MASK_15 = 17'h07FFF;
	localparam logic [16:0] TICK_MASK_16 = 17'h0FFFF;
	localparam logic [16:0] TICK_MASK_17 = 17'h1FFFF;

	localparam logic [7:0] LOS_TIMEOUT_CYCLES = 8'h10;

	typedef enum logic [2:0]
	{
		ST_RUN    = 3'h1,
		ST_HOLD   = 3'h2,
		ST_SWITCH = 3'h4
	} selState_t;

endpackage

`default_nettype wire

// ==== ref_clock_input_selector.sv ====
`timescale 1ns/1ps
`default_nettype none

module ref_clock_input_selector
(
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic [3:0] regAddr,
	input  wire logic [7:0] regWrData,
	input  wire logic       regWr,
	input  wire logic       regRd,
	output logic      [7:0] regRdData,
	input  wire logic [3:0] refClkIn,
	input  wire logic       vcxoClkIn,
	input  wire logic       pllLockedIn,
	output logic      [1:0] refSel,
	output logic      [3:0] inputEnable,
	output logic            pllLockLossStatus,
	output logic            pllLockLossLatched,
	output logic            lockOut,
	output logic            holdoverActive
);

	// ==========================================================================
	// Configuration registers
	// ==========================================================================
	logic [7:0] modeReg_r;
	logic [7:0] holdoffReg_r;
	logic [7:0] cfgReg_r;
	logic [7:0] prioReg_r;

	logic [1:0] selMode;
	logic [1:0] manualSel;
	logic       revsEn;
	logic       prescEn;
	logic       refLossMask;
	logic [1:0] tickDiv;
	logic [1:0] revalCode;
	logic [3:0] powerDown;
	logic       autoMode;

	assign selMode     = modeReg_r[ref_clock_pkg::MODE_SEL_LSB +: 2];
	assign manualSel   = modeReg_r[ref_clock_pkg::MAN_SEL_LSB +: 2];
	assign revsEn      = modeReg_r[ref_clock_pkg::REVERTIVE_SWITCH_ENABLE_BIT];
	assign prescEn     = modeReg_r[ref_clock_pkg::PRESC_BIT];
	assign refLossMask = modeReg_r[ref_clock_pkg::MASK_BIT];
	assign tickDiv     = cfgReg_r[ref_clock_pkg::CFG_DIV_LSB +: 2];
	assign revalCode   = cfgReg_r[ref_clock_pkg::CFG_REVAL_LSB +: 2];
	assign powerDown   = cfgReg_r[ref_clock_pkg::CFG_PD_LSB +: 4];

	// Low bit of the mode field marks the automatic modes.
	assign autoMode = selMode[0];

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			modeReg_r    <= ref_clock_pkg::MODE_RST;
			holdoffReg_r <= ref_clock_pkg::HOLDOFF_RST;
			cfgReg_r     <= ref_clock_pkg::CFG_RST;
			prioReg_r    <= ref_clock_pkg::PRIO_RST;
		end
		else if (regWr)
		begin
			case (regAddr)
				ref_clock_pkg::REG_MODE:    modeReg_r    <= {1'b0, regWrData[6:0]};
				ref_clock_pkg::REG_HOLDOFF: holdoffReg_r <= regWrData;
				ref_clock_pkg::REG_CFG:     cfgReg_r     <= regWrData;
				ref_clock_pkg::REG_PRIO:    prioReg_r    <= regWrData;
				default:                    ;
			endcase
		end
	end

	// ==========================================================================
	// Re-validation count decode
	// ==========================================================================
	logic [8:0] revalLoad;

	always_comb
	begin
		case ({prescEn, revalCode})
			3'h0:    revalLoad = ref_clock_pkg::REVAL_X1_0;
			3'h1:    revalLoad = ref_clock_pkg::REVAL_X1_1;
			3'h2:    revalLoad = ref_clock_pkg::REVAL_X1_2;
			3'h3:    revalLoad = ref_clock_pkg::REVAL_X1_3;
			3'h4:    revalLoad = ref_clock_pkg::REVAL_X4_0;
			3'h5:    revalLoad = ref_clock_pkg::REVAL_X4_1;
			3'h6:    revalLoad = ref_clock_pkg::REVAL_X4_2;
			default: revalLoad = ref_clock_pkg::REVAL_X4_3;
		endcase
	end

	// ==========================================================================
	// Per-input activity monitor
	// ==========================================================================
	logic [3:0] losFlag;
	logic [3:0] revalDone;

	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : gInput
			logic [2:0] sync_r;
			logic [1:0] presc_r;
			logic [7:0] timer_r;
			logic [8:0] reval_r;
			logic       los_r;
			logic       done_r;
			logic       inEdge;
			logic       periodTick;
			logic       missing;

			// Stage 0 feeds stage 1 only; edges are taken from stages 1 and 2.
			always_ff @(posedge clk or negedge arst_n)
			begin
				if (!arst_n)
					sync_r <= 3'h0;
				else
					sync_r <= {sync_r[1:0], refClkIn[g]};
			end

			assign inEdge     = sync_r[1] & ~sync_r[2] & ~powerDown[g];
			assign periodTick = inEdge & (~prescEn | (presc_r == 2'h3));
			assign missing    = (timer_r == ref_clock_pkg::LOS_TIMEOUT_CYCLES) & ~inEdge;

			always_ff @(posedge clk or negedge arst_n)
			begin
				if (!arst_n)
					presc_r <= 2'h0;
				else if (powerDown[g] || missing)
					presc_r <= 2'h0;
				else if (inEdge)
					presc_r <= presc_r + 2'h1;
			end

			// A powered-down input never counts, so it times out and stays lost.
			always_ff @(posedge clk or negedge arst_n)
			begin
				if (!arst_n)
					timer_r <= 8'h00;
				else if (inEdge || missing)
					timer_r <= 8'h00;
				else
					timer_r <= timer_r + 8'h01;
			end

			always_ff @(posedge clk or negedge arst_n)
			begin
				if (!arst_n)
				begin
					los_r   <= 1'b1;
					reval_r <= ref_clock_pkg::REVAL_X1_2;
					done_r  <= 1'b0;
				end
				else
				begin
					done_r <= 1'b0;
					if (missing || powerDown[g])
					begin
						los_r   <= 1'b1;
						reval_r <= revalLoad;
					end
					else if (los_r && periodTick)
					begin
						if (reval_r <= 9'h001)
						begin
							los_r   <= 1'b0;
							reval_r <= 9'h000;
							done_r  <= 1'b1;
						end
						else
							reval_r <= reval_r - 9'h001;
					end
				end
			end

			assign losFlag[g]   = los_r;
			assign revalDone[g] = done_r;
		end
	endgenerate

	// ==========================================================================
	// Hold-off tick from the VCXO clock
	// ==========================================================================
	logic [2:0]  vcxoSync_r;
	logic [16:0] vcxoCnt_r;
	logic [16:0] tickMask;
	logic        vcxoEdge;
	logic        holdTick;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			vcxoSync_r <= 3'h0;
		else
			vcxoSync_r <= {vcxoSync_r[1:0], vcxoClkIn};
	end

	assign vcxoEdge = vcxoSync_r[1] & ~vcxoSync_r[2];

	always_comb
	begin
		case (tickDiv)
			2'h0:    tickMask = ref_clock_pkg::TICK_MASK_15;
			2'h1:    tickMask = ref_clock_pkg::TICK_MASK_16;
			default: tickMask = ref_clock_pkg::TICK_MASK_17;
		endcase
	end

	// The VCXO is sampled, so this only holds while it runs well below clk.
	assign holdTick = vcxoEdge & ((vcxoCnt_r & tickMask) == tickMask);

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			vcxoCnt_r <= 17'h00000;
		else if (holdTick)
			vcxoCnt_r <= 17'h00000;
		else if (vcxoEdge)
			vcxoCnt_r <= vcxoCnt_r + 17'h00001;
	end

	// ==========================================================================
	// Priority search
	// ==========================================================================
	logic       bestFound;
	logic [1:0] bestIdx;
	logic [1:0] bestPrio;
	logic [1:0] curPrio;
	logic [1:0] autoSel_r;

	// Scanning from input 3 down with >= lets the lower index win a tie.
	always_comb
	begin
		bestFound = 1'b0;
		bestIdx   = 2'h0;
		bestPrio  = 2'h0;
		for (int i = 3; i >= 0; i--)
		begin
			if (!losFlag[i] && (!bestFound || prioReg_r[2*i +: 2] >= bestPrio))
			begin
				bestFound = 1'b1;
				bestIdx   = 2'(i);
				bestPrio  = prioReg_r[2*i +: 2];
			end
		end
	end

	assign curPrio = prioReg_r[{autoSel_r, 1'b0} +: 2];

	// ==========================================================================
	// Automatic selection state machine
	// ==========================================================================
	ref_clock_pkg::selState_t state_r;
	logic [7:0]               holdCnt_r;
	logic                     curLost;

	assign curLost = losFlag[autoSel_r];

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_r   <= ref_clock_pkg::ST_RUN;
			autoSel_r <= 2'h0;
			holdCnt_r <= 8'h00;
		end
		else
		begin
			case (state_r)
				ref_clock_pkg::ST_RUN:
				begin
					if (autoMode && curLost)
					begin
						if (selMode == ref_clock_pkg::MODE_AUTO_HOLD)
						begin
							state_r   <= ref_clock_pkg::ST_HOLD;
							holdCnt_r <= holdoffReg_r;
						end
						else if (bestFound)
							autoSel_r <= bestIdx;
					end
					else if (autoMode && revsEn && (|revalDone) && bestFound && bestPrio > curPrio)
						autoSel_r <= bestIdx;
				end
				ref_clock_pkg::ST_HOLD:
				begin
					if (selMode != ref_clock_pkg::MODE_AUTO_HOLD || !curLost)
						state_r <= ref_clock_pkg::ST_RUN;
					else if (holdTick)
					begin
						if (holdCnt_r <= 8'h01)
						begin
							state_r   <= ref_clock_pkg::ST_SWITCH;
							holdCnt_r <= holdoffReg_r;
						end
						else
							holdCnt_r <= holdCnt_r - 8'h01;
					end
				end
				ref_clock_pkg::ST_SWITCH:
				begin
					// With nothing valid the old input is kept and the wait restarts.
					if (bestFound)
						autoSel_r <= bestIdx;
					state_r <= ref_clock_pkg::ST_RUN;
				end
				default:
					state_r <= ref_clock_pkg::ST_RUN;
			endcase
		end
	end

	// ==========================================================================
	// Outputs
	// ==========================================================================
	logic       lossNow;
	logic       activeLost;
	logic [1:0] activeSel;
	logic [1:0] lockSync_r;
	logic       pllLockedOk_r;

	assign activeSel  = autoMode ? autoSel_r : manualSel;
	assign activeLost = losFlag[activeSel];
	assign lossNow    = ~pllLockedOk_r | (~refLossMask & activeLost);

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			lockSync_r    <= 2'h0;
			pllLockedOk_r <= 1'b0;
		end
		else
		begin
			lockSync_r    <= {lockSync_r[0], pllLockedIn};
			pllLockedOk_r <= lockSync_r[1];
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			refSel            <= 2'h0;
			inputEnable       <= 4'h0;
			pllLockLossStatus <= 1'b1;
			lockOut           <= 1'b0;
			holdoverActive    <= 1'b0;
		end
		else
		begin
			refSel            <= activeSel;
			inputEnable       <= ~powerDown;
			pllLockLossStatus <= lossNow;
			lockOut           <= ~lossNow;
			holdoverActive    <= (state_r == ref_clock_pkg::ST_HOLD);
		end
	end

	// A new loss in the clearing cycle keeps the latch set.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			pllLockLossLatched <= 1'b0;
		else if (lossNow)
			pllLockLossLatched <= 1'b1;
		else if (regWr && regAddr == ref_clock_pkg::REG_LATCH_CLR)
			pllLockLossLatched <= 1'b0;
	end

	// ==========================================================================
	// Read port
	// ==========================================================================
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			regRdData <= 8'h00;
		else if (regRd)
		begin
			case (regAddr)
				ref_clock_pkg::REG_MODE:    regRdData <= modeReg_r;
				ref_clock_pkg::REG_HOLDOFF: regRdData <= holdoffReg_r;
				ref_clock_pkg::REG_CFG:     regRdData <= cfgReg_r;
				ref_clock_pkg::REG_PRIO:    regRdData <= prioReg_r;
				ref_clock_pkg::REG_STATUS:
					regRdData <= {pllLockLossLatched, pllLockLossStatus, refSel, losFlag};
				default:                    regRdData <= 8'h00;
			endcase
		end
		else
			regRdData <= 8'h00;
	end

endmodule

`default_nettype wire

// ==== ref_clock_sources.sv ====
`timescale 1ns/1ps
`default_nettype none

// ====================
// Reference sources and VCXO. A stopped source stands still low, as a dead oscillator would.
module ref_clock_sources
(
	input  wire logic [3:0] run,
	output var  logic [3:0] refClk,
	output var  logic       vcxoClk
);
	initial refClk = 4'h0;
	initial vcxoClk = 1'b0;
	always #100 vcxoClk = ~vcxoClk;
	for (genvar i = 0; i < 4; i++)
	begin : g_src
		always #(70 + 10 * i) refClk[i] = run[i] ? ~refClk[i] : 1'b0;
	end
endmodule

`default_nettype wire

// ==== ref_clock_input_selector_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none

module ref_clock_input_selector_checker
(
	input wire logic       clk,
	input wire logic       arst_n,
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic       regWr,
	input wire logic       pllLockedIn,
	input wire logic [1:0] refSel,
	input wire logic [3:0] inputEnable,
	input wire logic       pllLockLossStatus,
	input wire logic       pllLockLossLatched,
	input wire logic       lockOut,
	input wire logic       holdoverActive
);
	// ====================
	// A shadow of the mode register, so mode rules need no internal probes.
	logic [1:0] modeR;
	logic       maskR;
	logic       modeWr;
	logic       cfgWr;
	assign modeWr = regWr && (regAddr == ref_clock_pkg::REG_MODE);
	assign cfgWr = regWr && (regAddr == ref_clock_pkg::REG_CFG);
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			modeR <= 2'h0;
			maskR <= 1'b0;
		end
		else if (modeWr)
		begin
			modeR <= regWrData[1:0];
			maskR <= regWrData[6];
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	property p_manual;
		logic [1:0] s;
		(modeWr && !regWrData[0], s = regWrData[3:2]) |-> ##2 refSel == s;
	endproperty
	a_manual: assert property (p_manual) else $error("manual select not routed");
	property p_pd;
		logic [3:0] v;
		(cfgWr, v = ~regWrData[7:4]) |-> ##2 inputEnable == v;
	endproperty
	a_pd: assert property (p_pd) else $error("power-down bits not applied");
	property p_enStable;
		($changed(inputEnable) && $past(arst_n, 2)) |-> ($past(cfgWr, 1) || $past(cfgWr, 2));
	endproperty
	a_enStable: assert property (p_enStable) else $error("input enable moved without write");
	property p_unlock;
		(!pllLockedIn) [*5] |=> pllLockLossStatus;
	endproperty
	a_unlock: assert property (p_unlock) else $error("lock loss not reported");
	property p_masked;
		(pllLockedIn && maskR) [*6] |-> !pllLockLossStatus;
	endproperty
	a_masked: assert property (p_masked) else $error("masked reference loss reported");
	property p_pin;
		lockOut != pllLockLossStatus;
	endproperty
	a_pin: assert property (p_pin) else $error("lock pin disagrees with status");
	property p_sticky;
		pllLockLossStatus |=> pllLockLossLatched;
	endproperty
	a_sticky: assert property (p_sticky) else $error("latched lock loss missed");
	property p_holdMode;
		holdoverActive |-> ($past(modeR, 2) == 2'h3);
	endproperty
	a_holdMode: assert property (p_holdMode) else $error("hold-off outside holdover mode");
	c_hold: cover property (holdoverActive);
	c_fail: cover property (modeR == 2'h1 && $changed(refSel));
	c_clear: cover property ($fell(pllLockLossLatched));
endmodule

bind ref_clock_input_selector ref_clock_input_selector_checker i_ref_clock_input_selector_checker
(
	.clk,
	.arst_n,
	.regAddr,
	.regWrData,
	.regWr,
	.pllLockedIn,
	.refSel,
	.inputEnable,
	.pllLockLossStatus,
	.pllLockLossLatched,
	.lockOut,
	.holdoverActive
);

`default_nettype wire

// ==== ref_clock_input_selector_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module ref_clock_input_selector_tb;
	logic       clk;
	logic       arst_n;
	logic [3:0] regAddr;
	logic [7:0] regWrData;
	logic       regWr;
	logic       regRd;
	logic [7:0] regRdData;
	logic [3:0] srcRun;
	logic [3:0] refClk;
	logic       vcxoClk;
	logic       pllLockedIn;
	logic [1:0] refSel;
	logic [3:0] inputEnable;
	logic       pllLockLossStatus;
	logic       pllLockLossLatched;
	logic       lockOut;
	logic       holdoverActive;
	int         err_count;
	int         tests_run;

	ref_clock_input_selector i_ref_clock_input_selector
	(
		.clk(clk),
		.arst_n(arst_n),
		.regAddr(regAddr),
		.regWrData(regWrData),
		.regWr(regWr),
		.regRd(regRd),
		.regRdData(regRdData),
		.refClkIn(refClk),
		.vcxoClkIn(vcxoClk),
		.pllLockedIn(pllLockedIn),
		.refSel(refSel),
		.inputEnable(inputEnable),
		.pllLockLossStatus(pllLockLossStatus),
		.pllLockLossLatched(pllLockLossLatched),
		.lockOut(lockOut),
		.holdoverActive(holdoverActive)
	);
	ref_clock_sources i_ref_clock_sources
	(
		.run(srcRun),
		.refClk(refClk),
		.vcxoClk(vcxoClk)
	);

	// ====================
	// Bus and comparison helpers.
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	task automatic rdchk(input string name, input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		@(negedge clk);
		chk(name, regRdData, exp);
	endtask
	task automatic lock(input logic v);
		@(posedge clk);
		pllLockedIn <= v;
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ====================
	// Scenarios.
	task automatic t_reset;
		rdchk("mode", ref_clock_pkg::REG_MODE, 8'h00);
		rdchk("holdoff", ref_clock_pkg::REG_HOLDOFF, 8'h80);
		rdchk("cfg", ref_clock_pkg::REG_CFG, 8'h0A);
		rdchk("prio", ref_clock_pkg::REG_PRIO, 8'h1B);
		rdchk("unmapped", 4'hF, 8'h00);
		chk("enable", inputEnable, 8'h0F);
	endtask
	task automatic t_reval;
		wt(30);
		rdchk("lossEarly", ref_clock_pkg::REG_STATUS, 8'hCF);
		wt(220);
		rdchk("revalidated", ref_clock_pkg::REG_STATUS, 8'h80);
	endtask
	task automatic t_manual;
		for (int m = 0; m < 4; m += 2)
			for (int s = 0; s < 4; s++)
			begin
				wr(ref_clock_pkg::REG_MODE, 8'(s * 4 + m));
				wt(3);
				chk("manualSel", refSel, 8'(s));
			end
	endtask
	task automatic t_mask;
		wr(ref_clock_pkg::REG_MODE, 8'h00);
		srcRun <= 4'hE;
		wt(30);
		chk("lossStatus", pllLockLossStatus, 8'h01);
		chk("lockPin", lockOut, 8'h00);
		wr(ref_clock_pkg::REG_MODE, 8'h40);
		wt(4);
		chk("maskedStatus", pllLockLossStatus, 8'h00);
		chk("maskedPin", lockOut, 8'h01);
		lock(1'b0);
		wt(8);
		chk("unlockStatus", pllLockLossStatus, 8'h01);
		lock(1'b1);
		wt(8);
		wr(ref_clock_pkg::REG_LATCH_CLR, 8'h00);
		wt(3);
		chk("latchClear", pllLockLossLatched, 8'h00);
		srcRun <= 4'hF;
		wr(ref_clock_pkg::REG_MODE, 8'h00);
		wt(200);
		chk("revalStatus", pllLockLossStatus, 8'h00);
	endtask
	task automatic t_auto;
		wr(ref_clock_pkg::REG_CFG, 8'h02);
		wr(ref_clock_pkg::REG_MODE, 8'h1D);
		wt(4);
		chk("autoIgnoresSel", refSel, 8'h00);
		srcRun <= 4'hE;
		wt(30);
		chk("failover", refSel, 8'h01);
		srcRun <= 4'hF;
		wt(30);
		chk("revert", refSel, 8'h00);
		wr(ref_clock_pkg::REG_MODE, 8'h0D);
		srcRun <= 4'hE;
		wt(30);
		srcRun <= 4'hF;
		wt(30);
		chk("noRevert", refSel, 8'h01);
	endtask
	task automatic t_hold;
		logic [1:0] cur;
		wr(ref_clock_pkg::REG_HOLDOFF, 8'h01);
		rdchk("holdoffRw", ref_clock_pkg::REG_HOLDOFF, 8'h01);
		wr(ref_clock_pkg::REG_CFG, 8'h00);
		wr(ref_clock_pkg::REG_MODE, 8'h03);
		wt(10);
		cur = refSel;
		srcRun <= 4'hC;
		wt(30);
		chk("holdActive", holdoverActive, 8'h01);
		chk("holdNoSwitch", refSel, 8'(cur));
		srcRun <= 4'hF;
		wr(ref_clock_pkg::REG_MODE, 8'h00);
	endtask
	task automatic t_pd;
		wr(ref_clock_pkg::REG_CFG, 8'h52);
		wt(3);
		chk("powerDown", inputEnable, 8'h0A);
		rdchk("cfgRw", ref_clock_pkg::REG_CFG, 8'h52);
		wr(ref_clock_pkg::REG_CFG, 8'h0A);
		wt(3);
		chk("powerUp", inputEnable, 8'h0F);
	endtask

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// The whole sequence needs under 2000 cycles; ten times that means a hang.
	initial
	begin
		repeat (20000) @(posedge clk);
		err_count++;
		end_of_test();
	end

	initial
	begin
		arst_n = 1'b0;
		regAddr = 4'h0;
		regWrData = 8'h00;
		regWr = 1'b0;
		regRd = 1'b0;
		srcRun = 4'hF;
		pllLockedIn = 1'b1;
		err_count = 0;
		tests_run = 0;
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		t_reset();
		t_reval();
		t_manual();
		t_mask();
		t_auto();
		t_hold();
		t_pd();
		end_of_test();
	end
endmodule

`default_nettype wire
